// ===== hw/rss_pkg.sv
// constants and lookup tables for the regulator sync master/slave block
package rss_pkg;

    // ************************************************************
    // clock and time base
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;             // MCLK period
    localparam int NS_PER_MS     = 1000000;        // ns per kHz-period numerator

    // ************************************************************
    // slave oscillator and slow-line limit
    // ************************************************************
    localparam int SLAVE_FREQ_KHZ = 250;           // slave oscillator, nominal
    localparam int SLOW_FREQ_KHZ  = 275;           // top of the 250 kHz strap's spread; the slave follows down to 250
    localparam int SLAVE_PERIOD_NS = NS_PER_MS / SLAVE_FREQ_KHZ;
    localparam logic [11:0] SLAVE_PERIOD_CYC = 12'(SLAVE_PERIOD_NS / CLK_PERIOD_NS);
    // longest period still counted as fast enough: rounds down
    localparam logic [11:0] SLOW_PERIOD_CYC =
        12'(NS_PER_MS / SLOW_FREQ_KHZ / CLK_PERIOD_NS);

    // ************************************************************
    // slave entry and pulses
    // ************************************************************
    localparam logic [3:0] ENTRY_PULSES = 4'ha;    // fast periods to enter slave
    localparam int DRIVE_PULSE_NS = 200;           // width of pulses we drive
    localparam logic [11:0] DRIVE_PULSE_CYC = 12'(DRIVE_PULSE_NS / CLK_PERIOD_NS);
    localparam int MIN_PULSE_NS = 100;             // least width from a master
    localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] STRAP_WINDOW_CYC = 5'h10; // strap sampling window
    localparam logic [2:0] OWN_ECHO_CYC = 3'h4;    // echo of own drive to ignore

    // ************************************************************
    // strap table: nominal rate and top of its spread, in kHz
    // ************************************************************
    localparam int FSW0_KHZ = 250;
    localparam int FSW1_KHZ = 500;
    localparam int FSW2_KHZ = 1000;
    localparam int FSW3_KHZ = 2000;
    localparam int SPREAD_PCT = 10;                // oscillator spread, plus side
    localparam logic [1:0] STRAP_RESET = 2'h1;     // strap value before capture

    typedef enum logic [1:0] {
        RSS_ST_STRAP,
        RSS_ST_MASTER,
        RSS_ST_SLAVE,
        RSS_ST_RETURN
    } rss_state_e;

    // nominal master period in cycles for a strap code
    function automatic logic [11:0] rss_nom_cyc(input logic [1:0] code);
        int khz;
        khz = (code == 2'h0) ? FSW0_KHZ : (code == 2'h1) ? FSW1_KHZ :
              (code == 2'h2) ? FSW2_KHZ : FSW3_KHZ;
        return 12'(NS_PER_MS / khz / CLK_PERIOD_NS);
    endfunction

    // longest period that is faster than the top of the spread
    function automatic logic [11:0] rss_fast_cyc(input logic [1:0] code);
        int khz;
        khz = (code == 2'h0) ? FSW0_KHZ : (code == 2'h1) ? FSW1_KHZ :
              (code == 2'h2) ? FSW2_KHZ : FSW3_KHZ;
        return 12'(NS_PER_MS * 100 / (khz * (100 + SPREAD_PCT)) / CLK_PERIOD_NS);
    endfunction

endpackage

// ===== hw/rss_line_if.sv
// carrier between the sync-line receiver and the controller
`timescale 1ns/1ps
`default_nettype none
interface rss_line_if;
    logic raw;    // pin level, asynchronous
    logic level;  // synchronised level
    logic rise;   // one-cycle rising edge
    modport rx (input raw, output level, output rise);
    modport ctl (output raw, input level, input rise);
endinterface
`default_nettype wire

// ===== hw/rss_line_rx.sv
// two-flop synchroniser and edge finder for the shared sync line
`timescale 1ns/1ps
`default_nettype none
module rss_line_rx (
    input  wire logic MCLK,
    input  wire logic RST,
    rss_line_if.rx    line
);
    logic meta_q;   // first stage, read only by the second
    logic lvl_q;    // second stage
    logic prev_q;   // delayed copy for edge finding
    logic rise_q;   // registered rising edge

    // ************************************************************
    // synchroniser and edge
    // ************************************************************
    // edge taken between stage two and its copy, never from stage one
    always_ff @(posedge MCLK) begin
        if (RST) begin
            meta_q <= 1'b0;
            lvl_q  <= 1'b0;
            prev_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            meta_q <= line.raw;
            lvl_q  <= meta_q;
            prev_q <= lvl_q;
            rise_q <= lvl_q & ~prev_q;
        end
    end

    assign line.level = lvl_q;
    assign line.rise  = rise_q;
endmodule
`default_nettype wire

// ===== hw/rss_sync_ctrl.sv
// master/slave synchronisation controller for the regulator oscillator
// Notes on behaviour
// - default master, pulses at strapped frequency
// - slave switches 180 degrees from master
// - slave switches in phase with reference
// - slave oscillator fixed at 250 kHz
// - ten fast periods move into slave
// - slave follows any sync rate down to 250 kHz
// - slow line: drive one pulse, back to master unless latched
// - line low at power-up latches slave
// - slope setting captured once at power-up
// - strap sampled once, then left floating
`timescale 1ns/1ps
`default_nettype none
module rss_sync_ctrl (
    input  wire logic       MCLK,              // 100 MHz system clock
    input  wire logic       RST,               // power-up / lockout reset
    input  wire logic       SYNC_IN,           // shared sync line, read back
    output logic            SYNC_OUT,          // level driven onto the line
    output logic            SYNC_OE_N,         // low while we drive the line
    input  wire logic [1:0] FREQ_SELECT_STRAP, // frequency strap pin
    output logic            STRAP_SAMPLE,      // strap bias on, sampling
    output logic [1:0]      SLOPE_SEL,         // slope compensation setting
    output logic            SOFTSTART_EN,      // strap done, switching allowed
    output logic            SW_PULSE,          // one-cycle switching start
    output logic            SLAVE_MODE,        // running as slave
    output logic            SLAVE_LATCHED      // slave latched until lockout
);

    // ************************************************************
    // declarations
    // ************************************************************
    rss_line_if line ();                  // synchronised sync line
    rss_pkg::rss_state_e state_q;         // operating mode
    logic [1:0]  strap_meta_q;            // strap first stage
    logic [1:0]  strap_sync_q;            // strap second stage
    logic [1:0]  strap_q;                 // captured strap
    logic [4:0]  win_q;                   // strap window counter
    logic        latched_q;               // latched slave
    logic [11:0] osc_q;                   // oscillator phase counter
    logic [11:0] since_q;                 // cycles since last outside rise
    logic [3:0]  cnt_q;                   // fast periods seen in a row
    logic        drive_q;                 // we drive the line high
    logic        sw_q;                    // switching pulse
    logic        sample_q;                // strap sampling window
    logic [2:0]  echo_q;                  // cycles since our drive ended
    logic [11:0] nom_cyc;                 // master period for this strap
    logic [11:0] fast_cyc;                // fastest-spread period bound
    logic        ext_rise;                // rise made by someone else
    logic        fast;                    // last period beat the spread
    logic        win_end;                 // last cycle of strap window
    logic        osc_wrap;                // oscillator end of period

    rss_line_rx u_rx (
        .MCLK (MCLK),
        .RST  (RST),
        .line (line.rx)
    );
    assign line.raw = SYNC_IN;

    // ************************************************************
    // decode
    // ************************************************************
    assign nom_cyc  = rss_pkg::rss_nom_cyc(strap_q);
    assign fast_cyc = rss_pkg::rss_fast_cyc(strap_q);
    // our own pulse comes back two flops late; ignore its echo
    assign ext_rise = line.rise & ~drive_q & (echo_q == rss_pkg::OWN_ECHO_CYC);
    assign fast     = (since_q <= fast_cyc);
    assign win_end  = (win_q == rss_pkg::STRAP_WINDOW_CYC - 5'h1);
    assign osc_wrap = (state_q == rss_pkg::RSS_ST_MASTER) ?
                      (osc_q >= nom_cyc - 12'h1) :
                      (osc_q >= rss_pkg::SLAVE_PERIOD_CYC - 12'h1);

    // ************************************************************
    // strap capture
    // ************************************************************
    // strap passes two flops, then is held for good
    always_ff @(posedge MCLK) begin
        if (RST) begin
            strap_meta_q <= 2'h0;
            strap_sync_q <= 2'h0;
            strap_q      <= rss_pkg::STRAP_RESET;
            win_q        <= 5'h0;
            sample_q     <= 1'b1;
        end else begin
            strap_meta_q <= FREQ_SELECT_STRAP;
            strap_sync_q <= strap_meta_q;
            if (state_q == rss_pkg::RSS_ST_STRAP) begin
                win_q <= win_q + 5'h1;
                if (win_end) begin
                    strap_q  <= strap_sync_q;
                    sample_q <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // outside period measure and entry count
    // ************************************************************
    // saturating, so the first edge after reset never counts as fast
    always_ff @(posedge MCLK) begin
        if (RST) begin
            since_q <= 12'hfff;
        end else if (ext_rise) begin
            since_q <= 12'h1;
        end else if (since_q != 12'hfff) begin
            since_q <= since_q + 12'h1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            cnt_q <= 4'h0;
        end else if (state_q != rss_pkg::RSS_ST_MASTER) begin
            cnt_q <= 4'h0;
        end else if (ext_rise) begin
            if (fast) begin
                cnt_q <= cnt_q + 4'h1;
            end else begin
                cnt_q <= 4'h0;
            end
        end
    end

    // ************************************************************
    // mode machine
    // ************************************************************
    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_q   <= rss_pkg::RSS_ST_STRAP;
            latched_q <= 1'b0;
        end else begin
            case (state_q)
                rss_pkg::RSS_ST_STRAP: begin
                    if (win_end) begin
                        // line held low by a master: latch slave
                        latched_q <= ~line.level;
                        state_q   <= line.level ? rss_pkg::RSS_ST_MASTER
                                                : rss_pkg::RSS_ST_SLAVE;
                    end
                end
                rss_pkg::RSS_ST_MASTER: begin
                    if (ext_rise && fast && cnt_q == rss_pkg::ENTRY_PULSES - 4'h1) begin
                        state_q <= rss_pkg::RSS_ST_SLAVE;
                    end
                end
                rss_pkg::RSS_ST_SLAVE: begin
                    // no edge for a whole 250 kHz period: line is slow
                    if (osc_wrap && !ext_rise) begin
                        state_q <= rss_pkg::RSS_ST_RETURN;
                    end
                end
                rss_pkg::RSS_ST_RETURN: begin
                    if (osc_q >= rss_pkg::DRIVE_PULSE_CYC - 12'h1) begin
                        // back to master only if the pulse got onto the line
                        if (line.level && !latched_q) begin
                            state_q <= rss_pkg::RSS_ST_MASTER;
                        end else begin
                            state_q <= rss_pkg::RSS_ST_SLAVE;
                        end
                    end
                end
                default: begin
                    state_q <= rss_pkg::RSS_ST_STRAP;
                end
            endcase
        end
    end

    // ************************************************************
    // oscillator and switching pulse
    // ************************************************************
    // slave restarts its phase on each outside rise, so it switches with
    // the line: 180 deg from a master that pulses mid-period, 0 deg to a
    // reference clock
    always_ff @(posedge MCLK) begin
        if (RST) begin
            osc_q <= 12'h0;
            sw_q  <= 1'b0;
        end else begin
            sw_q <= 1'b0;
            case (state_q)
                rss_pkg::RSS_ST_MASTER: begin
                    if (ext_rise && fast && cnt_q == rss_pkg::ENTRY_PULSES - 4'h1) begin
                        osc_q <= 12'h0;
                        sw_q  <= 1'b1;
                    end else if (osc_wrap) begin
                        osc_q <= 12'h0;
                        sw_q  <= 1'b1;
                    end else begin
                        osc_q <= osc_q + 12'h1;
                    end
                end
                rss_pkg::RSS_ST_SLAVE: begin
                    if (ext_rise) begin
                        osc_q <= 12'h0;
                        sw_q  <= 1'b1;
                    end else if (osc_wrap) begin
                        osc_q <= 12'h0;
                        sw_q  <= 1'b1;
                    end else begin
                        osc_q <= osc_q + 12'h1;
                    end
                end
                rss_pkg::RSS_ST_RETURN: begin
                    osc_q <= (osc_q >= rss_pkg::DRIVE_PULSE_CYC - 12'h1) ?
                             rss_pkg::DRIVE_PULSE_CYC : osc_q + 12'h1;
                end
                default: begin
                    osc_q <= 12'h0;
                end
            endcase
        end
    end

    // ************************************************************
    // line driver
    // ************************************************************
    // released between pulses so that an outside master can be heard;
    // a pull-down on the board gives the idle low
    always_ff @(posedge MCLK) begin
        if (RST) begin
            drive_q <= 1'b0;
        end else if (state_q == rss_pkg::RSS_ST_MASTER) begin
            drive_q <= (osc_q >= (nom_cyc >> 1)) &&
                       (osc_q < (nom_cyc >> 1) + rss_pkg::DRIVE_PULSE_CYC);
        end else if (state_q == rss_pkg::RSS_ST_SLAVE) begin
            drive_q <= osc_wrap && !ext_rise;
        end else if (state_q == rss_pkg::RSS_ST_RETURN) begin
            drive_q <= (osc_q < rss_pkg::DRIVE_PULSE_CYC - 12'h1);
        end else begin
            drive_q <= 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST || drive_q) begin
            echo_q <= 3'h0;
        end else if (echo_q != rss_pkg::OWN_ECHO_CYC) begin
            echo_q <= echo_q + 3'h1;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign SYNC_OUT      = drive_q;
    assign SYNC_OE_N     = ~drive_q;
    assign STRAP_SAMPLE  = sample_q;
    assign SLOPE_SEL     = strap_q;
    assign SOFTSTART_EN  = (state_q != rss_pkg::RSS_ST_STRAP);
    assign SW_PULSE      = sw_q;
    assign SLAVE_MODE    = (state_q == rss_pkg::RSS_ST_SLAVE) ||
                           (state_q == rss_pkg::RSS_ST_RETURN);
    assign SLAVE_LATCHED = latched_q;

    // ************************************************************
    // assertions
    // ************************************************************
    slope_hold_a: assert property (@(posedge MCLK) disable iff (RST)
        (state_q != rss_pkg::RSS_ST_STRAP) |=> $stable(strap_q))
        else $error("slope setting changed after capture");

    strap_float_a: assert property (@(posedge MCLK) disable iff (RST)
        (state_q != rss_pkg::RSS_ST_STRAP) |-> !sample_q)
        else $error("strap sampled after the window");

    master_period_a: assert property (@(posedge MCLK) disable iff (RST)
        (state_q == rss_pkg::RSS_ST_MASTER && osc_q == nom_cyc - 12'h1 && !ext_rise)
        |=> sw_q ##1 !sw_q)
        else $error("master period wrong");

    master_drive_a: assert property (@(posedge MCLK) disable iff (RST)
        (state_q == rss_pkg::RSS_ST_MASTER && osc_q == (nom_cyc >> 1) && !ext_rise)
        |=> drive_q [*8])
        else $error("master sync pulse missing");

    slave_phase_a: assert property (@(posedge MCLK) disable iff (RST)
        (state_q == rss_pkg::RSS_ST_SLAVE && ext_rise) |=> (sw_q && osc_q == 12'h0))
        else $error("slave not switching on the line edge");

    slave_osc_a: assert property (@(posedge MCLK) disable iff (RST)
        (state_q == rss_pkg::RSS_ST_SLAVE && osc_q == rss_pkg::SLAVE_PERIOD_CYC - 12'h1
         && !ext_rise) |=> (sw_q && drive_q && state_q == rss_pkg::RSS_ST_RETURN))
        else $error("slave oscillator period wrong");

    entry_a: assert property (@(posedge MCLK) disable iff (RST)
        (state_q == rss_pkg::RSS_ST_MASTER && ext_rise && fast
         && cnt_q == rss_pkg::ENTRY_PULSES - 4'h1) |=> SLAVE_MODE)
        else $error("slave entry missed");

    count_clear_a: assert property (@(posedge MCLK) disable iff (RST)
        (state_q == rss_pkg::RSS_ST_MASTER && ext_rise && !fast) |=> (cnt_q == 4'h0))
        else $error("entry count not restarted");

    return_a: assert property (@(posedge MCLK) disable iff (RST)
        $rose(state_q == rss_pkg::RSS_ST_RETURN) |-> drive_q [*8] ##1
        (state_q == rss_pkg::RSS_ST_RETURN) [*8])
        else $error("return pulse too short");

    latch_keep_a: assert property (@(posedge MCLK) disable iff (RST)
        latched_q |=> (latched_q && state_q != rss_pkg::RSS_ST_MASTER))
        else $error("latched slave left");
endmodule
`default_nettype wire

// ===== testbench/rss_sync_partner.sv
// far-side sync source: another regulator or an outside clock
`timescale 1ns/1ps
`default_nettype none
module rss_sync_partner (
    input  wire logic        run,       // emit pulses while high
    input  wire logic [15:0] period_ns, // pulse spacing in ns
    output logic             drv,       // level we put on the line
    output logic             drv_oe_n   // low while we drive
);
    // ************************************************************
    // pulse source, free of the block clock's phase
    // ************************************************************
    initial begin
        drv = 1'b0;
        drv_oe_n = 1'b1;
        #3;
        forever begin
            if (run) begin
                // 120 ns wide: above the least width a follower takes
                drv_oe_n = 1'b0;
                drv = 1'b1;
                #120;
                // released: the line's pull-down takes it low
                drv_oe_n = 1'b1;
                drv = 1'b0;
                // period stays under the longest one a follower holds, 4000 ns
                #(period_ns - 16'd120);
            end else begin
                #7; // idle poll, off the clock grid
            end
        end
    end
endmodule
`default_nettype wire

// ===== testbench/regulator_sync_master_slave_tb.sv
// self-checking bench for the sync master/slave controller
`timescale 1ns/1ps
`default_nettype none
module regulator_sync_master_slave_tb;
    // ************************************************************
    // clock, pins and far side
    // ************************************************************
    typedef struct {logic [1:0] code; logic [11:0] per;} rss_row_s;
    rss_row_s   rows [4] = '{'{2'h0, 12'h190}, '{2'h1, 12'h0c8},
                             '{2'h2, 12'h064}, '{2'h3, 12'h032}};
    logic        mclk;        // 100 MHz
    logic        rst;         // synchronous reset
    logic [1:0]  strap;       // strap pin
    logic        bias_hi;     // weak pull-up during power-up only
    logic        p_run;       // far side pulsing
    logic [15:0] p_per;       // far side period, ns
    logic        p_drv;
    logic        p_oe_n;
    logic        s_out;
    logic        s_oe_n;
    wire logic   s_line;      // resolved line
    logic [1:0]  slope;
    logic        smp;
    logic        ss_en;
    logic        swp;
    logic        slv;
    logic        lat;
    int          fail_count;
    int          checks_done;
    int          cyc = 0;     // timeout count
    int          n;
    int          w;

    // pull-down on the line unless someone drives it high
    assign s_line = (~s_oe_n & s_out) | (~p_oe_n & p_drv) | bias_hi;

    rss_sync_ctrl rss_sync_ctrl_inst (.MCLK(mclk), .RST(rst), .SYNC_IN(s_line),
        .SYNC_OUT(s_out), .SYNC_OE_N(s_oe_n), .FREQ_SELECT_STRAP(strap),
        .STRAP_SAMPLE(smp), .SLOPE_SEL(slope), .SOFTSTART_EN(ss_en),
        .SW_PULSE(swp), .SLAVE_MODE(slv), .SLAVE_LATCHED(lat));
    rss_sync_partner rss_sync_partner_inst (.run(p_run), .period_ns(p_per),
        .drv(p_drv), .drv_oe_n(p_oe_n));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    // cycles until the next switching start
    task automatic gap(output int c);
        c = 0;
        do begin
            @(negedge mclk);
            c++;
        end while (swp !== 1'b1 && c < 5000);
    endtask

    // wait for our next drive (d), then its width (c)
    task automatic drive_len(output int d, output int c);
        d = 0;
        c = 0;
        while (s_oe_n !== 1'b0 && d < 5000) begin
            @(negedge mclk);
            d++;
        end
        while (s_oe_n === 1'b0 && c < 100) begin
            @(negedge mclk);
            c++;
        end
    endtask

    // power-up with a strap and line level; hi keeps the line up
    task automatic do_reset(input logic [1:0] code, input logic hi);
        @(negedge mclk);
        rst = 1'b1;
        strap = code;
        bias_hi = hi;
        repeat (16) @(negedge mclk);
        chk("strap_sample", 12'h1, {11'h0, smp});
        chk("softstart", 12'h0, {11'h0, ss_en});
        rst = 1'b0;
        n = 0;
        while (ss_en !== 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        repeat (8) @(negedge mclk);
        bias_hi = 1'b0;
    endtask

    // exactly c outside pulses, then quiet
    task automatic burst(input int c);
        @(negedge mclk);
        p_run = 1'b1;
        repeat (c) @(posedge p_drv);
        p_run = 1'b0;
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count++;
            close_out();
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        rst = 1'b1;
        strap = 2'h1;
        bias_hi = 1'b1;
        p_run = 1'b0;
        p_per = 16'd800; // five steps of the 160 ns link base
        fail_count = 0;
        checks_done = 0;
        // master rate, drive width and phase per strap code
        foreach (rows[i]) begin
            do_reset(rows[i].code, 1'b1);
            chk("slope", {10'h0, rows[i].code}, {10'h0, slope});
            chk("master", 12'h0, {11'h0, slv});
            gap(n);
            gap(n);
            chk("period", rows[i].per, 12'(n));
            drive_len(w, n);
            chk("drive_width", 12'h014, 12'(n));
            chk("sync_out_idle", 12'h0, {11'h0, s_out});
            chk("half_phase", 12'h1, 12'(w >= rows[i].per / 2 && w <= rows[i].per / 2 + 1));
            $display("test strap %0d done", i);
        end
        // strap moves after capture: setting holds, bias is off
        strap = 2'h0;
        repeat (50) @(negedge mclk);
        chk("slope_held", 12'h3, {10'h0, slope});
        chk("strap_bias", 12'h0, {11'h0, smp});
        $display("test strap hold done");
        // two bursts of nine split by a slow gap must not add up
        do_reset(2'h1, 1'b1);
        burst(9);
        repeat (400) @(negedge mclk);
        burst(9);
        repeat (20) @(negedge mclk);
        chk("count_restart", 12'h0, {11'h0, slv});
        @(negedge mclk);
        p_run = 1'b1;
        n = 0;
        while (slv !== 1'b1 && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        chk("slave_entry", 12'h1, {11'h0, slv});
        chk("not_latched", 12'h0, {11'h0, lat});
        // follower switches on the outside edge
        @(posedge p_drv);
        gap(n);
        chk("follow_lag", 12'h1, 12'(n <= 6));
        chk("no_drive", 12'h1, {11'h0, s_oe_n});
        $display("test slave entry done");
        // outside source stops: one 250 kHz pulse, then master
        p_run = 1'b0;
        drive_len(w, n);
        chk("return_width", 12'h014, 12'(n));
        chk("return_wait", 12'h1, 12'(w >= 380 && w <= 500));
        repeat (4) @(negedge mclk);
        chk("back_master", 12'h0, {11'h0, slv});
        gap(n);
        gap(n);
        chk("master_again", 12'h0c8, 12'(n));
        $display("test slave return done");
        // line low at power-up latches slave at 250 kHz
        do_reset(2'h2, 1'b0);
        chk("latched", 12'h1, {11'h0, lat});
        chk("latched_slave", 12'h1, {11'h0, slv});
        drive_len(w, n);
        drive_len(w, n);
        chk("latched_rate", 12'h1, 12'(w >= 370 && w <= 410));
        chk("latch_holds", 12'h1, {11'h0, lat & slv});
        $display("test latched slave done");
        close_out();
    end
endmodule
`default_nettype wire
